// ### inc/sdoab_cfg.svh
// Constants of the SDO abort and error-reporting unit
`ifndef SDOAB_CFG_SVH
`define SDOAB_CFG_SVH

`define SDOAB_CMD_ABORT 8'h80
`define SDOAB_COB_RX 11'h600
`define SDOAB_COB_TX 11'h580
`define SDOAB_FRAME_LEN 4'h8
`define SDOAB_PDO_MAX_BYTES 4'h8

`define SDOAB_ERR_NONE 32'h00000000
`define SDOAB_ERR_TOGGLE 32'h05030000
`define SDOAB_ERR_CMD 32'h05040001
`define SDOAB_ERR_RDONLY 32'h06010002
`define SDOAB_ERR_NO_OBJ 32'h06020000
`define SDOAB_ERR_NO_MAP 32'h06040041
`define SDOAB_ERR_MAP_LEN 32'h06040042
`define SDOAB_ERR_TOO_LONG 32'h06070012
`define SDOAB_ERR_TOO_SHORT 32'h06070013
`define SDOAB_ERR_NO_SUB 32'h06090011
`define SDOAB_ERR_HIGH 32'h06090031
`define SDOAB_ERR_LOW 32'h06090032
`define SDOAB_ERR_GENERAL 32'h08000000
`define SDOAB_ERR_STATE 32'h08000022

`define SDOAB_IDX_ERRCNT 16'h1003
`define SDOAB_PDO_RXCOM 8'h14
`define SDOAB_PDO_RXMAP 8'h16
`define SDOAB_PDO_TXCOM 8'h18
`define SDOAB_PDO_TXMAP 8'h1A
`define SDOAB_PDO_LAST 8'h07

`define SDOAB_NMT_OPER 2'h1

`define SDOAB_ST_IDLE 2'h0
`define SDOAB_ST_CHECK 2'h1
`define SDOAB_ST_SEND 2'h3

`endif

// ### inc/sdoab_pkg.sv
// Types of the SDO abort and error-reporting unit
`include "sdoab_cfg.svh"
package sdoab_pkg;
	typedef enum logic [1:0] {
		SDOAB_IDLE = `SDOAB_ST_IDLE,
		SDOAB_CHECK = `SDOAB_ST_CHECK,
		SDOAB_SEND = `SDOAB_ST_SEND
	} sdoab_state_t;

	typedef struct packed {
		sdoab_state_t state;
		logic toggle;
		logic [63:0] frame;
		logic [31:0] code;
		logic [63:0] tx_data;
		logic tx_valid;
		logic peer_abort;
		logic req_ok;
		logic xfer_end;
	} sdoab_regs_t;
endpackage

// ### verilog/sdoab_abort.sv
// SDO server request checker and abort frame generator
`timescale 1ns/1ps
`include "sdoab_cfg.svh"
module sdoab_abort (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Node setting
	input wire logic [6:0] i_station_number,
	input wire logic [1:0] i_nmt_state,
	// Received CAN frame
	input wire logic i_rx_valid,
	input wire logic [10:0] i_rx_cob_id,
	input wire logic [63:0] i_rx_data,
	output logic o_rx_ready,
	// Transfer engine context
	input wire logic i_seg_active,
	input wire logic i_local_abort,
	input wire logic [31:0] i_local_code,
	// Dictionary lookup, answered during the check cycle
	output logic [15:0] o_object_index,
	output logic [7:0] o_lookup_sub,
	output logic o_lookup_write,
	input wire logic i_idx_exists,
	input wire logic i_sub_exists,
	input wire logic i_read_only,
	input wire logic [2:0] i_obj_bytes,
	input wire logic i_above_max,
	input wire logic i_below_min,
	input wire logic i_map_write,
	input wire logic i_not_mappable,
	input wire logic [3:0] i_map_bytes_new,
	input wire logic i_general_fail,
	// Outcome towards the transfer engine
	output logic o_req_ok,
	output logic [63:0] o_req_frame,
	output logic o_expect_toggle,
	output logic o_peer_abort,
	output logic o_xfer_end,
	// Abort frame towards the CAN controller
	output logic o_tx_valid,
	input wire logic i_tx_ready,
	output logic [10:0] o_tx_cob_id,
	output logic [3:0] o_tx_dlc,
	output logic [63:0] o_tx_data,
	output logic [31:0] o_abort_code
);
	import sdoab_pkg::*;

	sdoab_regs_t r_reg;
	sdoab_regs_t r_next;

	logic [7:0] cmd;
	logic [2:0] ccs;
	logic rx_hit;
	logic is_write;
	logic is_seg;
	logic is_init;
	logic [31:0] wr_len;
	logic [31:0] chk_code;

	// Client specifiers 4 and 7 are invalid except the exact abort byte
	function automatic logic cmd_allowed(input logic [7:0] c);
		cmd_allowed = (c[7:5] != 3'h4) && (c[7:5] != 3'h7);
	endfunction

	function automatic logic pdo_param(input logic [15:0] idx);
		pdo_param = ((idx[15:8] == `SDOAB_PDO_RXCOM) || (idx[15:8] == `SDOAB_PDO_RXMAP)
			|| (idx[15:8] == `SDOAB_PDO_TXCOM) || (idx[15:8] == `SDOAB_PDO_TXMAP))
			&& (idx[7:0] <= `SDOAB_PDO_LAST);
	endfunction

	function automatic logic [63:0] abort_frame(input logic [63:0] f, input logic [31:0] c);
		abort_frame = {c, f[31:8], `SDOAB_CMD_ABORT};
	endfunction

	assign cmd = r_reg.frame[7:0];
	assign ccs = cmd[7:5];
	assign rx_hit = i_rx_valid && (i_rx_cob_id == (`SDOAB_COB_RX + {4'h0, i_station_number}));
	assign is_init = (ccs == 3'h1) || (ccs == 3'h2) || (ccs == 3'h5) || (ccs == 3'h6);
	assign is_seg = (ccs == 3'h0) || (ccs == 3'h3);
	assign is_write = (ccs == 3'h1) || (ccs == 3'h6);
	// Expedited length from n, normal length from the size field
	assign wr_len = cmd[1] ? {29'h0, 3'h4 - {1'b0, cmd[3:2]}} : r_reg.frame[63:32];

	assign o_rx_ready = (r_reg.state == SDOAB_IDLE) && !i_local_abort;
	assign o_object_index = r_reg.frame[23:8];
	assign o_lookup_sub = r_reg.frame[31:24];
	assign o_lookup_write = is_write;
	assign o_req_ok = r_reg.req_ok;
	assign o_req_frame = r_reg.frame;
	assign o_expect_toggle = r_reg.toggle;
	assign o_peer_abort = r_reg.peer_abort;
	assign o_xfer_end = r_reg.xfer_end;
	assign o_tx_valid = r_reg.tx_valid;
	assign o_tx_cob_id = `SDOAB_COB_TX + {4'h0, i_station_number};
	assign o_tx_dlc = `SDOAB_FRAME_LEN;
	assign o_tx_data = r_reg.tx_data;
	assign o_abort_code = r_reg.code;

	// Fixed priority, so exactly one code wins
	always_comb begin
		chk_code = `SDOAB_ERR_NONE;
		if (!cmd_allowed(cmd)) begin
			chk_code = `SDOAB_ERR_CMD;
		end else if (is_seg && i_seg_active && (cmd[4] != r_reg.toggle)) begin
			chk_code = `SDOAB_ERR_TOGGLE;
		end else if (is_seg && !i_seg_active) begin
			chk_code = `SDOAB_ERR_CMD;
		end else if (is_init) begin
			if (!i_idx_exists) begin
				chk_code = `SDOAB_ERR_NO_OBJ;
			end else if (!i_sub_exists) begin
				chk_code = `SDOAB_ERR_NO_SUB;
			end else if (is_write && i_read_only) begin
				chk_code = `SDOAB_ERR_RDONLY;
			end else if (is_write && pdo_param(o_object_index)
				&& (i_nmt_state == `SDOAB_NMT_OPER)) begin
				chk_code = `SDOAB_ERR_STATE;
			end else if (is_write && cmd[0] && (wr_len > {29'h0, i_obj_bytes})) begin
				chk_code = `SDOAB_ERR_TOO_LONG;
			end else if (is_write && cmd[0] && (wr_len < {29'h0, i_obj_bytes})) begin
				chk_code = `SDOAB_ERR_TOO_SHORT;
			end else if (is_write && (o_object_index == `SDOAB_IDX_ERRCNT)
				&& (o_lookup_sub == 8'h00) && (r_reg.frame[63:32] != 32'h0)) begin
				chk_code = `SDOAB_ERR_HIGH;
			end else if (is_write && i_above_max) begin
				chk_code = `SDOAB_ERR_HIGH;
			end else if (is_write && i_below_min) begin
				chk_code = `SDOAB_ERR_LOW;
			end else if (is_write && i_map_write && i_not_mappable) begin
				chk_code = `SDOAB_ERR_NO_MAP;
			end else if (is_write && i_map_write && (i_map_bytes_new > `SDOAB_PDO_MAX_BYTES)) begin
				chk_code = `SDOAB_ERR_MAP_LEN;
			end else if (i_general_fail) begin
				chk_code = `SDOAB_ERR_GENERAL;
			end
		end else if (i_general_fail) begin
			chk_code = `SDOAB_ERR_GENERAL;
		end
	end

	always_comb begin
		r_next = r_reg;
		r_next.peer_abort = 1'b0;
		r_next.req_ok = 1'b0;
		r_next.xfer_end = 1'b0;
		case (r_reg.state)
			SDOAB_IDLE: begin
				if (i_local_abort) begin
					// Own abort names the last request's object
					r_next.code = i_local_code;
					r_next.tx_data = abort_frame(r_reg.frame, i_local_code);
					r_next.tx_valid = 1'b1;
					r_next.toggle = 1'b0;
					r_next.state = SDOAB_SEND;
				end else if (rx_hit) begin
					if (i_rx_data[7:0] == `SDOAB_CMD_ABORT) begin
						// Peer code is deliberately not looked at
						r_next.peer_abort = 1'b1;
						r_next.xfer_end = 1'b1;
						r_next.toggle = 1'b0;
					end else begin
						r_next.frame = i_rx_data;
						r_next.state = SDOAB_CHECK;
					end
				end
			end
			SDOAB_CHECK: begin
				if (chk_code != `SDOAB_ERR_NONE) begin
					r_next.code = chk_code;
					r_next.tx_data = abort_frame(r_reg.frame, chk_code);
					r_next.tx_valid = 1'b1;
					r_next.toggle = 1'b0;
					r_next.state = SDOAB_SEND;
				end else begin
					r_next.req_ok = 1'b1;
					if (is_init) begin
						r_next.toggle = 1'b0;
					end else if (is_seg) begin
						r_next.toggle = ~r_reg.toggle;
					end
					r_next.state = SDOAB_IDLE;
				end
			end
			SDOAB_SEND: begin
				if (i_tx_ready) begin
					r_next.tx_valid = 1'b0;
					r_next.xfer_end = 1'b1;
					r_next.state = SDOAB_IDLE;
				end
			end
			default: begin
				r_next.state = SDOAB_IDLE;
				r_next.tx_valid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r_reg <= '0;
		end else if (i_ce) begin
			r_reg <= r_next;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_bad_cmd;
		(r_reg.state == SDOAB_CHECK) && i_ce && !cmd_allowed(cmd);
	endsequence

	sequence s_peer_abort_in;
		(r_reg.state == SDOAB_IDLE) && i_ce && !i_local_abort && rx_hit
			&& (i_rx_data[7:0] == `SDOAB_CMD_ABORT);
	endsequence

	sequence s_fault_seen;
		(r_reg.state == SDOAB_CHECK) && i_ce && (chk_code != `SDOAB_ERR_NONE);
	endsequence

	property p_cmd_code;
		s_bad_cmd |=> o_tx_valid && (o_abort_code == `SDOAB_ERR_CMD);
	endproperty
	a_cmd_code: assert property (p_cmd_code) else $error("bad command not aborted");

	property p_peer_no_reply;
		s_peer_abort_in |=> o_peer_abort && !o_tx_valid && (r_reg.state == SDOAB_IDLE);
	endproperty
	a_peer_no_reply: assert property (p_peer_no_reply) else $error("peer abort answered");

	property p_peer_toggle;
		s_peer_abort_in |=> !o_expect_toggle;
	endproperty
	a_peer_toggle: assert property (p_peer_toggle) else $error("toggle kept after abort");

	property p_frame_layout;
		o_tx_valid |-> (o_tx_data[7:0] == `SDOAB_CMD_ABORT)
			&& (o_tx_data[63:32] == o_abort_code) && (o_tx_dlc == `SDOAB_FRAME_LEN);
	endproperty
	a_frame_layout: assert property (p_frame_layout) else $error("abort frame layout wrong");

	property p_tx_cob;
		o_tx_valid |-> (o_tx_cob_id == `SDOAB_COB_TX + {4'h0, i_station_number});
	endproperty
	a_tx_cob: assert property (p_tx_cob) else $error("abort sent on wrong identifier");

	property p_one_abort;
		s_fault_seen ##1 (i_ce && i_tx_ready) |=> !o_tx_valid && (r_reg.state == SDOAB_IDLE)
			&& o_xfer_end;
	endproperty
	a_one_abort: assert property (p_one_abort) else $error("abort not single");

	property p_hold_abort;
		(o_tx_valid && !i_tx_ready) |=> o_tx_valid && $stable(o_tx_data);
	endproperty
	a_hold_abort: assert property (p_hold_abort) else $error("abort dropped before taken");

	property p_state_code;
		(r_reg.state == SDOAB_CHECK) && i_ce && cmd_allowed(cmd) && is_init && i_idx_exists
			&& i_sub_exists && is_write && !i_read_only && pdo_param(o_object_index)
			&& (i_nmt_state == `SDOAB_NMT_OPER) |=> (o_abort_code == `SDOAB_ERR_STATE);
	endproperty
	a_state_code: assert property (p_state_code) else $error("PDO write in operational kept");

	property p_no_obj;
		(r_reg.state == SDOAB_CHECK) && i_ce && cmd_allowed(cmd) && is_init && !i_idx_exists
			|=> o_tx_valid && (o_abort_code == `SDOAB_ERR_NO_OBJ);
	endproperty
	a_no_obj: assert property (p_no_obj) else $error("missing object not aborted");

	property p_local_abort;
		(r_reg.state == SDOAB_IDLE) && i_ce && i_local_abort
			|=> o_tx_valid && (o_abort_code == $past(i_local_code));
	endproperty
	a_local_abort: assert property (p_local_abort) else $error("own abort not sent");

	sequence s_init_check;
		(r_reg.state == SDOAB_CHECK) && i_ce && cmd_allowed(cmd) && is_init;
	endsequence

	property p_toggle_code;
		(r_reg.state == SDOAB_CHECK) && i_ce && cmd_allowed(cmd) && is_seg && i_seg_active
			&& (cmd[4] != o_expect_toggle) |=> o_tx_valid && (o_abort_code == `SDOAB_ERR_TOGGLE);
	endproperty
	a_toggle_code: assert property (p_toggle_code) else $error("stale toggle not aborted");

	property p_seg_flip;
		(r_reg.state == SDOAB_CHECK) && i_ce && is_seg && (chk_code == `SDOAB_ERR_NONE)
			|=> o_req_ok && (o_expect_toggle != $past(o_expect_toggle));
	endproperty
	a_seg_flip: assert property (p_seg_flip) else $error("toggle not alternated");

	property p_no_sub;
		s_init_check ##0 (i_idx_exists && !i_sub_exists)
			|=> o_tx_valid && (o_abort_code == `SDOAB_ERR_NO_SUB);
	endproperty
	a_no_sub: assert property (p_no_sub) else $error("missing subindex not aborted");

	property p_rdonly;
		s_init_check ##0 (i_idx_exists && i_sub_exists && is_write && i_read_only)
			|=> o_tx_valid && (o_abort_code == `SDOAB_ERR_RDONLY);
	endproperty
	a_rdonly: assert property (p_rdonly) else $error("read-only write not aborted");
endmodule

// ### tb/sdoab_can_ctl.sv
// CAN controller model that takes abort frames from the unit
`timescale 1ns/1ps
module sdoab_can_ctl (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Abort frame from the unit
	input wire logic i_tx_valid,
	input wire logic [63:0] i_tx_data,
	input wire logic [3:0] i_stall,
	output logic o_tx_ready,
	// Capture seen by the bench
	output logic o_took,
	output logic [63:0] o_frame
);
	logic [3:0] wait_reg;
	// Ready held across one taking edge only, so a slow stall is exercised
	always @(negedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_tx_ready <= 1'b0;
			wait_reg <= 4'h0;
		end else if (o_tx_ready) begin
			o_tx_ready <= 1'b0;
			wait_reg <= 4'h0;
		end else if (i_tx_valid) begin
			o_tx_ready <= (wait_reg >= i_stall);
			wait_reg <= wait_reg + 4'h1;
		end
	end
	// An abort is only taken, never confirmed
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_took <= 1'b0;
			o_frame <= 64'h0;
		end else begin
			o_took <= o_tx_ready & i_tx_valid;
			if (o_tx_ready & i_tx_valid)
				o_frame <= i_tx_data;
		end
	end
endmodule

// ### tb/tb_sdoab_abort.sv
// Self-checking bench of the SDO abort unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_sdoab_abort;
	logic i_clk = 0, i_rst_n = 0, i_ce = 1, i_rx_valid = 0, i_seg_active = 0, i_local_abort = 0;
	logic i_idx_exists, i_sub_exists, i_read_only, i_above_max, i_below_min, i_map_write;
	logic i_not_mappable, i_general_fail, i_tx_ready, o_rx_ready, o_lookup_write, o_req_ok;
	logic o_expect_toggle, o_peer_abort, o_xfer_end, o_tx_valid, took;
	logic tog = 1'b0;
	logic [63:0] exp_frame;
	logic [6:0] i_station_number = 7'h01;
	logic [1:0] i_nmt_state = 2'h0;
	logic [10:0] i_rx_cob_id = 11'h0, o_tx_cob_id;
	logic [63:0] i_rx_data = 64'h0, o_req_frame, o_tx_data, frame;
	logic [31:0] i_local_code = 32'h0, o_abort_code;
	logic [15:0] o_object_index, last_idx = 16'h0;
	logic [7:0] o_lookup_sub, last_sub = 8'h0, flags = 8'h03;
	logic [2:0] i_obj_bytes = 3'h4;
	logic [3:0] i_map_bytes_new = 4'h0, o_tx_dlc, stall = 4'h0;
	logic [15:0] pdo [4] = '{16'h1400, 16'h1607, 16'h1807, 16'h1A07};
	logic [63:0] exp_q [$];
	int bad_count = 0;
	int cmp_count = 0;
	assign {i_general_fail, i_not_mappable, i_map_write, i_below_min, i_above_max, i_read_only,
		i_sub_exists, i_idx_exists} = flags;
	always #4 i_clk = ~i_clk;
	sdoab_abort i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
		.i_station_number(i_station_number), .i_nmt_state(i_nmt_state), .i_rx_valid(i_rx_valid),
		.i_rx_cob_id(i_rx_cob_id), .i_rx_data(i_rx_data), .o_rx_ready(o_rx_ready),
		.i_seg_active(i_seg_active), .i_local_abort(i_local_abort), .i_local_code(i_local_code),
		.o_object_index(o_object_index), .o_lookup_sub(o_lookup_sub),
		.o_lookup_write(o_lookup_write), .i_idx_exists(i_idx_exists), .i_sub_exists(i_sub_exists),
		.i_read_only(i_read_only), .i_obj_bytes(i_obj_bytes), .i_above_max(i_above_max),
		.i_below_min(i_below_min), .i_map_write(i_map_write), .i_not_mappable(i_not_mappable),
		.i_map_bytes_new(i_map_bytes_new), .i_general_fail(i_general_fail), .o_req_ok(o_req_ok),
		.o_req_frame(o_req_frame), .o_expect_toggle(o_expect_toggle),
		.o_peer_abort(o_peer_abort), .o_xfer_end(o_xfer_end), .o_tx_valid(o_tx_valid),
		.i_tx_ready(i_tx_ready), .o_tx_cob_id(o_tx_cob_id), .o_tx_dlc(o_tx_dlc),
		.o_tx_data(o_tx_data), .o_abort_code(o_abort_code));
	sdoab_can_ctl i_can (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tx_valid(o_tx_valid),
		.i_tx_data(o_tx_data), .i_stall(stall), .o_tx_ready(i_tx_ready), .o_took(took),
		.o_frame(frame));
	// Pop once, the compare macro reads its arguments twice
	always @(negedge i_clk)
		if (took === 1'b1) begin
			exp_frame = (exp_q.size() > 0) ? exp_q.pop_front() : 64'h0;
			`CHK("frame at controller", exp_frame, frame)
		end
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic setd(input logic [7:0] f, input logic [2:0] ob, input logic [3:0] mb,
		input logic [1:0] ns, input logic sg);
		@(negedge i_clk);
		flags = f;
		i_obj_bytes = ob;
		i_map_bytes_new = mb;
		i_nmt_state = ns;
		i_seg_active = sg;
		stall = 4'($urandom_range(0, 7));
	endtask
	task automatic wait_end;
		int n;
		n = 0;
		while (o_xfer_end !== 1'b1 && n < 30) begin
			@(negedge i_clk);
			n++;
		end
		`CHK("transfer end", 1'b1, o_xfer_end)
		`CHK("released", 1'b0, o_tx_valid)
	endtask
	// Reference abort code, in rule priority order
	function automatic logic [31:0] ref_code(input logic [7:0] c, input logic [15:0] ix,
		input logic [7:0] sb, input logic [31:0] v);
		logic [31:0] n;
		logic wr;
		logic sg;
		n = c[1] ? 32'(4 - c[3:2]) : v;
		wr = (c[7:5] == 3'h1) || (c[7:5] == 3'h6);
		sg = (c[7:5] == 3'h0) || (c[7:5] == 3'h3);
		if ((c[7:5] == 3'h4) || (c[7:5] == 3'h7) || (sg && !i_seg_active))
			return 32'h05040001;
		if (sg)
			return (c[4] != tog) ? 32'h05030000 : (i_general_fail ? 32'h08000000 : 32'h0);
		if (!i_idx_exists)
			return 32'h06020000;
		if (!i_sub_exists)
			return 32'h06090011;
		if (wr && i_read_only)
			return 32'h06010002;
		if (wr && ((ix[15:8] == 8'h14) || (ix[15:8] == 8'h16) || (ix[15:8] == 8'h18)
			|| (ix[15:8] == 8'h1A)) && (ix[7:0] < 8'h08) && (i_nmt_state == 2'h1))
			return 32'h08000022;
		if (wr && c[0] && (n != 32'(i_obj_bytes)))
			return (n > 32'(i_obj_bytes)) ? 32'h06070012 : 32'h06070013;
		if (wr && (((ix == 16'h1003) && (sb == 8'h00) && (v != 0)) || i_above_max))
			return 32'h06090031;
		if (wr && i_below_min)
			return 32'h06090032;
		if (wr && i_map_write && (i_not_mappable || (i_map_bytes_new > 4'h8)))
			return i_not_mappable ? 32'h06040041 : 32'h06040042;
		return i_general_fail ? 32'h08000000 : 32'h0;
	endfunction
	// Entered at a falling edge; dictionary answers already set
	task automatic req(input logic [7:0] cmd, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] val, input logic [31:0] code);
		logic [31:0] mcode;
		mcode = (cmd == 8'h80) ? 32'h0 : ref_code(cmd, idx, sub, val);
		`CHK("ready", 1'b1, o_rx_ready)
		i_rx_valid = 1;
		i_rx_cob_id = 11'h600 + 11'(i_station_number);
		i_rx_data = {val, sub, idx, cmd};
		@(negedge i_clk);
		i_rx_valid = 0;
		if (cmd == 8'h80) begin
			`CHK("peer abort", 1'b1, o_peer_abort)
			`CHK("end on peer abort", 1'b1, o_xfer_end)
		end else begin
			last_idx = idx;
			last_sub = sub;
			`CHK("lookup index", idx, o_object_index)
			`CHK("lookup sub", sub, o_lookup_sub)
			`CHK("write flag", cmd[7:5] == 3'h1, o_lookup_write)
		end
		@(negedge i_clk);
		`CHK("request ok", code == 0 && cmd != 8'h80, o_req_ok)
		`CHK("model verdict", mcode == 0 && cmd != 8'h80, o_req_ok)
		`CHK("abort sent", code != 0, o_tx_valid)
		if (mcode == 0 && cmd != 8'h80)
			`CHK("request frame", {val, sub, idx, cmd}, o_req_frame)
		if (code != 0) begin
			exp_q.push_back({code, sub, idx, 8'h80});
			`CHK("abort code", code, o_abort_code)
			`CHK("model code", mcode, o_abort_code)
			`CHK("abort data", {code, sub, idx, 8'h80}, o_tx_data)
			`CHK("reply id", 11'h580 + 11'(i_station_number), o_tx_cob_id)
			`CHK("length", 4'h8, o_tx_dlc)
			wait_end();
		end
		if (cmd == 8'h80 || mcode != 0 || !(cmd[7:5] == 3'h0 || cmd[7:5] == 3'h3))
			tog = 1'b0;
		else
			tog = ~tog;
		`CHK("expected toggle", tog, o_expect_toggle)
	endtask
	initial begin
		#(8 * 20000);
		bad_count++;
		results();
	end
	initial begin
		void'($urandom(25));
		i_station_number = 7'($urandom_range(1, 127));
		repeat (2) @(negedge i_clk);
		i_rst_n = 1;
		setd(8'h03, 3'h4, 4'h0, 2'h0, 1'b0);
		req(8'h23, 16'h607A, 8'h00, $urandom, 32'h0);
		req(8'hE0, 16'h607A, 8'h00, $urandom, 32'h05040001);
		req(8'h90, 16'h607A, 8'h00, $urandom, 32'h05040001);
		setd(8'h01, 3'h4, 4'h0, 2'h0, 1'b0);
		req(8'h23, 16'h2000, 8'h05, $urandom, 32'h06090011);
		setd(8'h00, 3'h4, 4'h0, 2'h0, 1'b0);
		req(8'h23, 16'h2FFF, 8'h00, $urandom, 32'h06020000);
		setd(8'h04, 3'h4, 4'h0, 2'h0, 1'b0);
		req(8'h23, 16'h2FFF, 8'h00, $urandom, 32'h06020000);
		setd(8'h07, 3'h4, 4'h0, 2'h0, 1'b0);
		req(8'h23, 16'h1000, 8'h00, $urandom, 32'h06010002);
		setd(8'h03, 3'h4, 4'h0, 2'h1, 1'b0);
		for (int i = 0; i < 4; i++)
			req(8'h23, pdo[i], 8'h01, $urandom, 32'h08000022);
		req(8'h23, 16'h1A08, 8'h01, $urandom, 32'h0);
		setd(8'h03, 3'h1, 4'h0, 2'h0, 1'b0);
		req(8'h23, 16'h2001, 8'h00, $urandom, 32'h06070012);
		req(8'h2F, 16'h1003, 8'h00, 32'h1, 32'h06090031);
		req(8'h2F, 16'h1003, 8'h00, 32'h0, 32'h0);
		setd(8'h03, 3'h4, 4'h0, 2'h0, 1'b0);
		req(8'h2F, 16'h2002, 8'h00, $urandom, 32'h06070013);
		setd(8'h0B, 3'h4, 4'h0, 2'h0, 1'b0);
		req(8'h23, 16'h2003, 8'h00, $urandom, 32'h06090031);
		setd(8'h13, 3'h4, 4'h0, 2'h0, 1'b0);
		req(8'h23, 16'h2003, 8'h00, $urandom, 32'h06090032);
		setd(8'h63, 3'h4, 4'h4, 2'h0, 1'b0);
		req(8'h23, 16'h1600, 8'h01, $urandom, 32'h06040041);
		setd(8'h23, 3'h4, 4'h9, 2'h0, 1'b0);
		req(8'h23, 16'h1600, 8'h02, $urandom, 32'h06040042);
		setd(8'h23, 3'h4, 4'h8, 2'h0, 1'b0);
		req(8'h23, 16'h1600, 8'h02, $urandom, 32'h0);
		setd(8'h83, 3'h4, 4'h0, 2'h0, 1'b0);
		req(8'h23, 16'h2004, 8'h00, $urandom, 32'h08000000);
		$display("test dictionary faults done");
		setd(8'h03, 3'h4, 4'h0, 2'h0, 1'b1);
		req(8'h40, 16'h100A, 8'h00, 32'h0, 32'h0);
		req(8'h60, 16'h100A, 8'h00, 32'h0, 32'h0);
		`CHK("toggle flips", 1'b1, o_expect_toggle)
		req(8'h60, 16'h100A, 8'h00, 32'h0, 32'h05030000);
		`CHK("toggle cleared", 1'b0, o_expect_toggle)
		req(8'h40, 16'h100A, 8'h00, 32'h0, 32'h0);
		req(8'h60, 16'h100A, 8'h00, 32'h0, 32'h0);
		setd(8'h03, 3'h4, 4'h0, 2'h0, 1'b0);
		req(8'h60, 16'h100A, 8'h00, 32'h0, 32'h05040001);
		$display("test segments done");
		req(8'h80, 16'h100A, 8'h00, $urandom, 32'h0);
		req(8'h80, 16'h100A, 8'h00, 32'h0, 32'h0);
		req(8'h23, 16'h607A, 8'h00, $urandom, 32'h0);
		i_local_abort = 1;
		i_local_code = $urandom | 32'h1;
		@(negedge i_clk);
		i_local_abort = 0;
		exp_q.push_back({i_local_code, last_sub, last_idx, 8'h80});
		`CHK("own abort", i_local_code, o_abort_code)
		wait_end();
		tog = 1'b0;
		$display("test aborts done");
		i_rx_valid = 1;
		i_rx_cob_id = 11'h580 + 11'(i_station_number);
		@(negedge i_clk);
		i_rx_valid = 0;
		// A wrongly taken frame would show its one-cycle verdict here
		@(negedge i_clk);
		`CHK("foreign id ignored", 1'b0, o_req_ok | o_tx_valid)
		$display("test foreign id done");
		i_ce = 0;
		i_rx_valid = 1;
		i_rx_cob_id = 11'h600 + 11'(i_station_number);
		@(negedge i_clk);
		i_rx_valid = 0;
		i_ce = 1;
		@(negedge i_clk);
		`CHK("frozen while disabled", 1'b1, o_rx_ready)
		`CHK("no verdict while disabled", 1'b0, o_req_ok | o_tx_valid)
		$display("test enable done");
		`CHK("frames left", 0, exp_q.size())
		results();
	end
endmodule
